// file: verilog/pssd_defines.svh
// Constants of the pipelined sync SRAM cycle decoder.
`ifndef PSSD_DEFINES_SVH
`define PSSD_DEFINES_SVH

`define PSSD_LANE_BITS    9
`define PSSD_APB_AW       12
`define PSSD_CTRL_OFS     12'h000
`define PSSD_STATUS_OFS   12'h004
`define PSSD_CTRL_OVR_BIT 0
`define PSSD_CTRL_LIN_BIT 1
`define PSSD_CTRL_RST     2'h0
`define PSSD_SLEEP_CYCLES 2'h2

`endif

// file: verilog/pssd_pkg.sv
// Types shared by the SRAM cycle decoder files.
package pssd_pkg;

  typedef enum logic [2:0] {
    OP_DESELECT = 3'h0,
    OP_SLEEP    = 3'h1,
    OP_RD_BEGIN = 3'h2,
    OP_WR_BEGIN = 3'h3,
    OP_RD_NEXT  = 3'h4,
    OP_WR_NEXT  = 3'h5,
    OP_RD_CUR   = 3'h6,
    OP_WR_CUR   = 3'h7
  } pssd_op_t;

  typedef struct packed {
    logic ce1N;
    logic ce2;
    logic ce3N;
    logic adspN;
    logic adscN;
    logic advN;
    logic gwN;
    logic bweN;
  } pssd_ctrl_t;

  typedef struct packed {
    pssd_op_t   op;
    logic       asleep;
    logic       drive;
    logic [1:0] low;
  } pssd_status_t;

endpackage

// file: verilog/pssd_burst_counter.sv
// Two-bit wrapping burst counter with XOR or incrementing order.
`timescale 1ns/1ps
module pssd_burst_counter (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       load,
  input  wire logic       advance,
  input  wire logic [1:0] startBits,
  input  wire logic       linear,
  output logic      [1:0] curLow,
  output logic      [1:0] nxtLow
);

  logic [1:0] start_r;
  logic [1:0] start_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [1:0] cntInc;

  always_comb begin
    cntInc    = cnt_r + 2'h1;
    start_nxt = start_r;
    cnt_nxt   = cnt_r;
    if (load) begin
      start_nxt = startBits;
      cnt_nxt   = 2'h0;
    end else if (advance) begin
      cnt_nxt = cntInc;
    end
    // Two-bit arithmetic wraps by itself, which gives the four-beat wrap.
    curLow = linear ? start_r + cnt_r  : start_r ^ cnt_r;
    nxtLow = linear ? start_r + cntInc : start_r ^ cntInc;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= 2'h0;
      cnt_r   <= 2'h0;
    end else if (clkEn) begin
      start_r <= start_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule // pssd_burst_counter

// file: verilog/pssd_cycle_decode.sv
// Cycle decoder, write lane control and output drive of a pipelined sync SRAM.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "pssd_defines.svh"
module pssd_cycle_decode #(
  parameter int ADDR_W = 19,
  parameter int LANES  = 4
) (
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  input  wire logic                             clkEn,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [`PSSD_APB_AW-1:0]          paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic                             chip_enable_primary_n,
  input  wire logic                             depth_select_high,
  input  wire logic                             depth_select_low_n,
  input  wire logic                             sleep_request,
  input  wire logic                             processor_addr_strobe_n,
  input  wire logic                             controller_addr_strobe_n,
  input  wire logic                             burst_advance_n,
  input  wire logic                             global_write_n,
  input  wire logic                             byte_write_gate_n,
  input  wire logic [LANES-1:0]                 byte_lane_write_n,
  input  wire logic                             outEnableN,
  input  wire logic                             burstOrderSel,
  input  wire logic [ADDR_W-1:0]                extAddr,
  input  wire logic [LANES*`PSSD_LANE_BITS-1:0] dqIn,
  output logic      [LANES*`PSSD_LANE_BITS-1:0] dqOut,
  output logic                                  dqOeN,
  input  wire logic [LANES*`PSSD_LANE_BITS-1:0] memRdData,
  output logic      [ADDR_W-1:0]                memAddr,
  output logic                                  memRd,
  output logic                                  memWr,
  output logic      [LANES-1:0]                 memLanes,
  output logic      [LANES*`PSSD_LANE_BITS-1:0] memWrData
);

  localparam int DW = LANES * `PSSD_LANE_BITS;

  if (LANES < 1 || LANES > 8 || ADDR_W < 3) begin : g_bad_params
    $error("pssd_cycle_decode: unsupported ADDR_W or LANES");
  end

  // ****************************************************************
  // Pin decode
  // ****************************************************************
  pssd_pkg::pssd_ctrl_t pins;
  pssd_pkg::pssd_op_t   decOp;
  logic                 chipSel;
  logic                 writeReq;
  logic                 sleepBlock;
  logic                 decRead;
  logic                 decWrite;
  logic [LANES-1:0]     laneSel;

  assign pins = {chip_enable_primary_n, depth_select_high, depth_select_low_n,
                 processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
                 global_write_n, byte_write_gate_n};

  always_comb begin
    chipSel  = !pins.ce1N && pins.ce2 && !pins.ce3N;
    writeReq = !pins.gwN || (!pins.bweN && !(&byte_lane_write_n));
    if (!pins.gwN) begin
      laneSel = '1;
    end else begin
      laneSel = pins.bweN ? '0 : ~byte_lane_write_n;
    end
    if (sleepBlock) begin
      decOp = pssd_pkg::OP_SLEEP;
    end else if (!pins.ce1N && !pins.adspN) begin
      // The write inputs are deliberately not looked at here.
      decOp = chipSel ? pssd_pkg::OP_RD_BEGIN : pssd_pkg::OP_DESELECT;
    end else if (!pins.adscN) begin
      if (!chipSel) begin
        decOp = pssd_pkg::OP_DESELECT;
      end else begin
        decOp = writeReq ? pssd_pkg::OP_WR_BEGIN : pssd_pkg::OP_RD_BEGIN;
      end
    end else if (!pins.advN) begin
      decOp = writeReq ? pssd_pkg::OP_WR_NEXT : pssd_pkg::OP_RD_NEXT;
    end else begin
      decOp = writeReq ? pssd_pkg::OP_WR_CUR : pssd_pkg::OP_RD_CUR;
    end
    decRead  = decOp == pssd_pkg::OP_RD_BEGIN || decOp == pssd_pkg::OP_RD_NEXT ||
               decOp == pssd_pkg::OP_RD_CUR;
    decWrite = decOp == pssd_pkg::OP_WR_BEGIN || decOp == pssd_pkg::OP_WR_NEXT ||
               decOp == pssd_pkg::OP_WR_CUR;
  end

  // ****************************************************************
  // Sleep entry and exit
  // ****************************************************************
  logic [1:0] sleepCnt_r;
  logic [1:0] sleepCnt_nxt;
  logic       asleep_r;
  logic       asleep_nxt;

  // Inputs are ignored from the first high sample until recovery ends.
  assign sleepBlock = sleep_request || asleep_r;

  always_comb begin
    sleepCnt_nxt = 2'h0;
    asleep_nxt   = asleep_r;
    if (sleep_request != asleep_r) begin
      if (sleepCnt_r + 2'h1 == `PSSD_SLEEP_CYCLES) begin
        asleep_nxt = sleep_request;
      end else begin
        sleepCnt_nxt = sleepCnt_r + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Burst address and memory request
  // ****************************************************************
  logic [1:0]          ctrl_r;
  logic [1:0]          curLow;
  logic [1:0]          nxtLow;
  logic                linear;
  logic                isBegin;
  logic                isNext;
  pssd_pkg::pssd_op_t  op_r;
  logic [ADDR_W-1:2]   base_r;
  logic [ADDR_W-1:2]   base_nxt;
  logic [ADDR_W-1:0]   memAddr_nxt;
  logic [LANES-1:0]    memLanes_nxt;
  logic [DW-1:0]       memWrData_nxt;
  logic [DW-1:0]       dqOut_nxt;

  // Software may override the mode pin; low on the pin means incrementing order.
  assign linear  = ctrl_r[`PSSD_CTRL_OVR_BIT] ? ctrl_r[`PSSD_CTRL_LIN_BIT]
                                              : !burstOrderSel;
  assign isBegin = decOp == pssd_pkg::OP_RD_BEGIN || decOp == pssd_pkg::OP_WR_BEGIN;
  assign isNext  = decOp == pssd_pkg::OP_RD_NEXT || decOp == pssd_pkg::OP_WR_NEXT;

  pssd_burst_counter u_counter (
    .clk       (clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .load      (isBegin),
    .advance   (isNext),
    .startBits (extAddr[1:0]),
    .linear    (linear),
    .curLow    (curLow),
    .nxtLow    (nxtLow)
  );

  always_comb begin
    base_nxt      = isBegin ? extAddr[ADDR_W-1:2] : base_r;
    memAddr_nxt   = memAddr;
    memLanes_nxt  = decWrite ? laneSel : '0;
    memWrData_nxt = decWrite ? dqIn : memWrData;
    dqOut_nxt     = memRd ? memRdData : dqOut;
    if (isBegin) begin
      memAddr_nxt = extAddr;
    end else if (isNext) begin
      memAddr_nxt = {base_r, nxtLow};
    end else if (decRead || decWrite) begin
      memAddr_nxt = {base_r, curLow};
    end
  end

  // ****************************************************************
  // Output drive with double-cycle deselect
  // ****************************************************************
  logic drive_r;
  logic drive_nxt;
  logic linger_r;
  logic linger_nxt;

  always_comb begin
    drive_nxt  = drive_r;
    linger_nxt = 1'b0;
    unique case (decOp)
      pssd_pkg::OP_RD_BEGIN, pssd_pkg::OP_RD_NEXT, pssd_pkg::OP_RD_CUR: begin
        drive_nxt = 1'b1;
      end
      pssd_pkg::OP_WR_BEGIN, pssd_pkg::OP_WR_NEXT, pssd_pkg::OP_WR_CUR,
      pssd_pkg::OP_SLEEP: begin
        drive_nxt = 1'b0;
      end
      pssd_pkg::OP_DESELECT: begin
        // One extra cycle of drive lets a depth-expanded neighbour take over cleanly.
        drive_nxt  = linger_r ? 1'b0 : drive_r;
        linger_nxt = !linger_r && drive_r;
      end
    endcase
  end

  // The drive enable pin is only gated, never registered, so it acts at once.
  assign dqOeN = !(drive_r && !outEnableN && !decWrite && !memWr && !sleepBlock);

  // ****************************************************************
  // APB registers
  // ****************************************************************
  logic                   ctrlHit;
  logic                   statHit;
  logic [1:0]             ctrl_nxt;
  logic [31:0]            prdata_nxt;
  pssd_pkg::pssd_status_t status;

  assign ctrlHit = paddr == `PSSD_CTRL_OFS;
  assign statHit = paddr == `PSSD_STATUS_OFS;
  assign pready  = clkEn;
  assign pslverr = psel && penable && !ctrlHit && !statHit;
  assign status  = '{op: op_r, asleep: asleep_r, drive: drive_r, low: curLow};

  always_comb begin
    ctrl_nxt   = ctrl_r;
    prdata_nxt = prdata;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      if (ctrlHit) begin
        prdata_nxt[1:0] = ctrl_r;
      end else if (statHit) begin
        prdata_nxt[$bits(status)-1:0] = status;
      end
    end
    if (psel && penable && pwrite && ctrlHit) begin
      ctrl_nxt = pwdata[1:0];
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepCnt_r <= 2'h0;
      asleep_r   <= 1'b0;
      op_r       <= pssd_pkg::OP_DESELECT;
      base_r     <= '0;
      memAddr    <= '0;
      memRd      <= 1'b0;
      memWr      <= 1'b0;
      memLanes   <= '0;
      memWrData  <= '0;
      dqOut      <= '0;
      drive_r    <= 1'b0;
      linger_r   <= 1'b0;
      ctrl_r     <= `PSSD_CTRL_RST;
      prdata     <= 32'h0000_0000;
    end else if (clkEn) begin
      sleepCnt_r <= sleepCnt_nxt;
      asleep_r   <= asleep_nxt;
      op_r       <= decOp;
      base_r     <= base_nxt;
      memAddr    <= memAddr_nxt;
      memRd      <= decRead;
      memWr      <= decWrite;
      memLanes   <= memLanes_nxt;
      memWrData  <= memWrData_nxt;
      dqOut      <= dqOut_nxt;
      drive_r    <= drive_nxt;
      linger_r   <= linger_nxt;
      ctrl_r     <= ctrl_nxt;
      prdata     <= prdata_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic cleanIn;
  assign cleanIn = clkEn && !sleepBlock;

  sequence s_desel_drive;
    clkEn && decOp == pssd_pkg::OP_DESELECT && drive_r && !linger_r;
  endsequence

  sequence s_sleep_hold;
    (clkEn && sleep_request)[*2];
  endsequence

  a_processor_addr_strobe_n_read_begin: assert property (cleanIn && chipSel && !processor_addr_strobe_n
    |=> memRd && !memWr && memAddr == $past(extAddr)) else $error("strobe read lost");
  a_controller_addr_strobe_n_write_begin: assert property (cleanIn && chipSel && processor_addr_strobe_n
    && !controller_addr_strobe_n && writeReq
    |=> memWr && memAddr == $past(extAddr)) else $error("write begin lost");
  a_controller_addr_strobe_n_read_begin: assert property (cleanIn && chipSel && processor_addr_strobe_n
    && !controller_addr_strobe_n && !writeReq
    |=> memRd && op_r == pssd_pkg::OP_RD_BEGIN) else $error("read begin lost");
  a_deselect_idle: assert property (cleanIn && !chipSel && (!controller_addr_strobe_n
    || (!chip_enable_primary_n && !processor_addr_strobe_n))
    |=> !memRd && !memWr && memAddr == $past(memAddr)) else $error("deselect used memory");
  a_read_next: assert property (cleanIn && controller_addr_strobe_n && !burst_advance_n
    && (processor_addr_strobe_n || chip_enable_primary_n) && !writeReq
    |=> memRd && memAddr[ADDR_W-1:2] == $past(memAddr[ADDR_W-1:2])) else $error("read next");
  a_write_next: assert property (cleanIn && controller_addr_strobe_n && !burst_advance_n
    && (processor_addr_strobe_n || chip_enable_primary_n) && writeReq
    |=> memWr && op_r == pssd_pkg::OP_WR_NEXT) else $error("write next");
  a_read_hold: assert property (clkEn && $past(clkEn) && op_r == pssd_pkg::OP_RD_CUR
    && $past(memRd || memWr) |-> memRd && memAddr == $past(memAddr)) else $error("read hold");
  a_write_hold: assert property (clkEn && $past(clkEn) && op_r == pssd_pkg::OP_WR_CUR
    && $past(memRd || memWr) |-> memWr && memAddr == $past(memAddr)) else $error("write hold");
  a_lane_select: assert property (cleanIn && decWrite |=> memLanes == $past(
    global_write_n ? ~byte_lane_write_n : {LANES{1'b1}})) else $error("lane mismatch");
  a_read_no_lanes: assert property (memRd |-> memLanes == '0 && !memWr) else $error("read wrote");
  a_write_tristate: assert property (decWrite || memWr |-> dqOeN) else $error("drove in write");
  a_read_drive: assert property (drive_r && !memWr && !decWrite && !sleepBlock
    |-> dqOeN == outEnableN) else $error("read drive wrong");
  a_sleep_entry: assert property (s_sleep_hold |=> asleep_r && dqOeN) else $error("sleep");
  a_sleep_not_one: assert property (clkEn && !asleep_r && sleepCnt_r == 2'h0
    |=> !asleep_r) else $error("sleep too early");
  a_desel_keep: assert property (s_desel_drive |=> drive_r) else $error("dropped early");
  a_desel_release: assert property (s_desel_drive ##1 (clkEn && decOp == pssd_pkg::OP_DESELECT)
    |=> !drive_r) else $error("drive kept too long");

endmodule // pssd_cycle_decode

// file: verification/pssd_ctrl_model.sv
// Behavioural memory controller that drives the SRAM pins of the decoder.
`timescale 1ns/1ps
module pssd_ctrl_model (
  input  wire logic              clk,
  output pssd_pkg::pssd_ctrl_t   ctrl,
  output logic                   sleepReq,
  output logic [3:0]             lanesN,
  output logic                   oeN,
  output logic [18:0]            addr,
  output logic [35:0]            dq
);
  // **********************************************************
  // Pin driver
  // **********************************************************
  initial begin
    ctrl     = pssd_pkg::pssd_ctrl_t'(8'hD7);
    sleepReq = 1'b0;
    lanesN   = 4'hF;
    oeN      = 1'b1;
    addr     = 19'h00000;
    dq       = 36'h000000000;
  end

  // Called just after a rising edge; values land by non-blocking assignment.
  task automatic drive(input logic [7:0] c, input logic [3:0] ln, input logic oe,
                       input logic zz, input logic [18:0] a, input logic [35:0] d);
    pssd_pkg::pssd_ctrl_t cs;
    logic                 wrBegin;
    cs = pssd_pkg::pssd_ctrl_t'(c);
    // A write starts only from the controller strobe, never a processor start.
    wrBegin = cs.adspN && !cs.adscN && (!cs.gwN || (!cs.bweN && ln != 4'hF));
    ctrl     <= cs;
    sleepReq <= zz;
    lanesN   <= ln;
    // Output enable goes high in the same cycle as a write start so the pins are free.
    oeN      <= wrBegin ? 1'b1 : oe;
    addr     <= a;
    // The data bus always carries the caller's pattern d, which repeats when the address repeats.
    dq       <= d;
  endtask

  task automatic set_oe(input logic oe);
    oeN <= oe;
  endtask
endmodule // pssd_ctrl_model

// file: verification/pssd_cycle_decode_tb.sv
// Self-checking testbench of the SRAM cycle decoder.
`timescale 1ns/1ps
module pssd_cycle_decode_tb;
  logic                 clk;
  logic                 rst_n;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 burstOrderSel;
  pssd_pkg::pssd_ctrl_t ctrl;
  logic                 sleepReq;
  logic [3:0]           lanesN;
  logic                 oeN;
  logic [18:0]          extAddr;
  logic [35:0]          dqIn;
  logic [35:0]          dqOut;
  logic                 dqOeN;
  logic [18:0]          memAddr;
  logic                 memRd;
  logic                 memWr;
  logic [3:0]           memLanes;
  logic [35:0]          memWrData;
  logic [31:0]          rd;
  logic                 err;
  int                   n_mismatch;
  int                   n_compared;

  // **********************************************************
  // Instances
  // **********************************************************
  pssd_ctrl_model model_u (.clk(clk), .ctrl(ctrl), .sleepReq(sleepReq), .lanesN(lanesN),
                           .oeN(oeN), .addr(extAddr), .dq(dqIn));

  pssd_cycle_decode dut_u (
    .clk(clk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_enable_primary_n(ctrl.ce1N), .depth_select_high(ctrl.ce2),
    .depth_select_low_n(ctrl.ce3N), .sleep_request(sleepReq),
    .processor_addr_strobe_n(ctrl.adspN), .controller_addr_strobe_n(ctrl.adscN),
    .burst_advance_n(ctrl.advN), .global_write_n(ctrl.gwN), .byte_write_gate_n(ctrl.bweN),
    .byte_lane_write_n(lanesN), .outEnableN(oeN), .burstOrderSel(burstOrderSel),
    .extAddr(extAddr), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
    .memRdData({4{memAddr[8:0]}}), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
    .memLanes(memLanes), .memWrData(memWrData));

  always #4 clk = ~clk;

  // **********************************************************
  // Tasks
  // **********************************************************
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) n_mismatch++;
    check("pready", pready, 36'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  // One pin cycle: drive, let the sampling edge pass, settle.
  task automatic step(input logic [7:0] c, input logic [3:0] ln, input logic oe,
                      input logic zz, input logic [18:0] a);
    // The data pattern comes from the stimulus only, so expectations stay independent.
    model_u.drive(c, ln, oe, zz, a, ~{a[8:0], a[18:0], 8'h5A});
    @(posedge clk); #1;
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    wrap_up;
  end

  // **********************************************************
  // Tests
  // **********************************************************
  initial begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 12'h000; pwdata = 32'h00000000; burstOrderSel = 1'b1;
    n_mismatch = 0; n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk); #1;
    apb(1'b0, 12'h000, 32'h00000000); check("ctrl reset", rd, 36'h0);
    apb(1'b0, 12'h008, 32'h00000000); check("unmapped err", err, 36'h1);
    // Processor start with global write low must still read.
    step(8'h4D, 4'h0, 1'b0, 1'b0, 19'h12341);
    check("processor_addr_strobe_n rd", {memRd, memWr, memAddr}, {2'b10, 19'h12341});
    check("rd drive", dqOeN, 36'h0);
    model_u.set_oe(1'b1); #1;
    check("oe async", dqOeN, 36'h1);
    step(8'h5B, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("rd next", {memRd, memAddr}, {1'b1, 19'h12340});
    check("rd data", dqOut, {4{9'h141}});
    step(8'h59, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("wr next", {memWr, memLanes, memAddr}, {5'h1F, 19'h12343});
    check("wr tristate", dqOeN, 36'h1);
    step(8'h5D, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("wr cur", {memWr, memAddr}, {1'b1, 19'h12343});
    step(8'h5F, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("rd cur", {memRd, memWr, memAddr}, {2'b10, 19'h12343});
    step(8'hCB, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("rd next ce1", {memRd, memAddr}, {1'b1, 19'h12342});
    step(8'hD7, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("desel", {memRd, memWr}, 36'h0);
    check("desel hold", dqOeN, 36'h0);
    step(8'hD7, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("desel off", dqOeN, 36'h1);
    step(8'h55, 4'hF, 1'b1, 1'b0, 19'h00AA0);
    check("gw write", {memWr, memLanes, memAddr}, {5'h1F, 19'h00AA0});
    check("gw data", memWrData, ~{9'h0A0, 19'h00AA0, 8'h5A});
    step(8'h56, 4'hA, 1'b1, 1'b0, 19'h00AB0);
    check("byte lanes", {memWr, memLanes}, 36'h15);
    step(8'h56, 4'hF, 1'b0, 1'b0, 19'h00AC0);
    check("no lane rd", {memRd, memWr, memLanes}, 36'h20);
    step(8'hD7, 4'hF, 1'b0, 1'b1, 19'h00000);
    step(8'hD7, 4'hF, 1'b0, 1'b1, 19'h00000);
    step(8'h4D, 4'hF, 1'b0, 1'b1, 19'h00100);
    check("sleep rd", {memRd, memWr, dqOeN}, 36'h1);
    step(8'hD7, 4'hF, 1'b0, 1'b0, 19'h00000);
    step(8'hD7, 4'hF, 1'b0, 1'b0, 19'h00000);
    step(8'hD7, 4'hF, 1'b0, 1'b0, 19'h00000);
    step(8'h4D, 4'hF, 1'b0, 1'b0, 19'h00100);
    check("wake rd", {memRd, memAddr}, {1'b1, 19'h00100});
    apb(1'b1, 12'h000, 32'h00000003);
    apb(1'b0, 12'h000, 32'h00000000); check("ctrl rw", rd, 36'h3);
    step(8'h4D, 4'hF, 1'b0, 1'b0, 19'h00005);
    step(8'h5B, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("linear next", memAddr, 36'h00006);
    apb(1'b1, 12'h000, 32'h00000000);
    burstOrderSel <= 1'b0;
    step(8'h4D, 4'hF, 1'b0, 1'b0, 19'h00007);
    step(8'h5B, 4'hF, 1'b0, 1'b0, 19'h00000);
    check("pin linear", memAddr, 36'h00004);
    wrap_up;
  end
endmodule // pssd_cycle_decode_tb
